/* File: spe_pkg.sv */
// Contract
// - Erase of one location sets every bit of that byte or word to one.
// - Erase cycle launches on chip select falling after a fully decoded address.
// - Every instruction bit on the data input is captured at rising serial clock.
// - Chip select must fall before the clock edge after the last data bit.
// - A started cycle completes on its own timer whatever the serial clock does.
// - Every write erases the target location before programming it; fill-all here programs all locations with no prior erase.
// - Bulk clear sets the whole array to ones; address bits after the 10 code are don't care.
// - Fill-all writes the supplied byte or word into every array location.
// - While busy, serial output is low whenever chip select is high.
// - While busy, serial input and clock activity is ignored.
// - After the cycle ends and select is high, serial output shows high.
// - Ready level holds until select falls or a new start bit arrives.
// - The array holds all ones before any programming.
// - Clock pulses are counted from start bit to chip select falling.
// - A wrong pulse count aborts write or erase instructions, array unchanged.
// - Byte write with nine address bits needs exactly twenty clocks.
// - Start bit one; write 01, erase 11; 00 with 10 clears, 01 fills.
// - Write and erase need a prior enable; locked at power-up and by lock.
package spe_pkg;

   localparam int CLK_PERIOD_NS = 40;
   localparam int START_BITS    = 1;
   localparam int OPC_W         = 2;
   localparam int SUB_W         = 2;
   localparam int CNT_W         = 6;
   localparam int DEF_ADDR_W    = 9;
   localparam int DEF_DATA_W    = 8;
   localparam int DEF_PROG_NS   = 4000000;

   localparam logic [OPC_W-1:0] OP_WRITE = 2'h1;
   localparam logic [OPC_W-1:0] OP_ERASE = 2'h3;
   localparam logic [OPC_W-1:0] OP_MISC  = 2'h0;

   localparam logic [SUB_W-1:0] SUB_BULK_CLEAR = 2'h2;
   localparam logic [SUB_W-1:0] SUB_FILL_ALL   = 2'h1;
   localparam logic [SUB_W-1:0] SUB_UNLOCK     = 2'h3;
   localparam logic [SUB_W-1:0] SUB_LOCK       = 2'h0;

   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_WRITE,
      CMD_ERASE,
      CMD_BULK_CLEAR,
      CMD_FILL_ALL,
      CMD_UNLOCK,
      CMD_LOCK
   } spe_cmd_t;

   typedef enum logic {
      ST_IDLE,
      ST_BUSY
   } spe_state_t;

endpackage

/* File: spe_frame_if.sv */
`timescale 1ns/1ns
interface spe_frame_if #(
   parameter int SH_W  = 19,
   parameter int CNT_W = 6
);
   logic [SH_W-1:0]  bits;
   logic [CNT_W-1:0] count;
   logic             start_tgl;

   modport front (output bits, output count, output start_tgl);
   modport core  (input bits, input count, input start_tgl);
endinterface

/* File: spe_front.sv */
`timescale 1ns/1ns
module spe_front
   import spe_pkg::*;
#(
   parameter int ADDR_W = DEF_ADDR_W,
   parameter int DATA_W = DEF_DATA_W
)
(
   // Serial link
   input  wire logic     sclk,
   input  wire logic     cs,
   input  wire logic     din,
   // System reset, carried into the link domain
   input  wire logic     rst_n,
   // Frame towards the core
   spe_frame_if.front    frm
);

   localparam int SH_W = OPC_W + ADDR_W + DATA_W;
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   logic             rst_m_q;
   logic             rst_s_q;
   logic             open_q;
   logic [CNT_W-1:0] count_q;
   logic [SH_W-1:0]  bits_q;
   logic             tgl_q;

   always_ff @(posedge sclk)
   begin
      rst_m_q <= rst_n;
      rst_s_q <= rst_m_q;
   end

   // The link clock stands still between frames, so it would never see select
   // low. Select low therefore clears the open flag at once, without a clock.
   always_ff @(posedge sclk or negedge cs)
   begin
      if (!cs)
      begin
         open_q <= 1'b0;
      end
      else
      begin
         open_q <= 1'b1;
      end
   end

   // The frame is held after select falls and is only cleared when the next
   // frame opens, so the core can read it safely after its own select sync.
   always_ff @(posedge sclk)
   begin
      if (!rst_s_q)
      begin
         count_q <= '0;
         bits_q  <= '0;
         tgl_q   <= 1'b0;
      end
      else if (cs)
      begin
         if (!open_q || count_q == '0)
         begin
            if (!open_q)
            begin
               bits_q <= '0;
            end
            if (din)
            begin
               count_q <= CNT_W'(START_BITS);
               tgl_q   <= ~tgl_q;
            end
            else
            begin
               count_q <= '0;
            end
         end
         else
         begin
            bits_q <= {bits_q[SH_W-2:0], din};
            if (count_q != CNT_MAX)
            begin
               count_q <= count_q + 1'b1;
            end
         end
      end
   end

   assign frm.bits      = bits_q;
   assign frm.count     = count_q;
   assign frm.start_tgl = tgl_q;

endmodule // spe_front

/* File: spe_top.sv */
`timescale 1ns/1ns
module spe_top
   import spe_pkg::*;
#(
   parameter int ADDR_W      = DEF_ADDR_W,
   parameter int DATA_W      = DEF_DATA_W,
   parameter int PROG_TIME_NS = DEF_PROG_NS
)
(
   // System clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // Serial link
   input  wire logic              sclk,
   input  wire logic              cs,
   input  wire logic              din,
   output logic                   dout,
   output logic                   dout_oe,
   // Array inspection
   input  wire logic [ADDR_W-1:0] peek_addr,
   output logic [DATA_W-1:0]      peek_data
);

   localparam int SH_W     = OPC_W + ADDR_W + DATA_W;
   localparam int DEPTH    = 1 << ADDR_W;
   localparam int PROG_RAW = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int PROG_CYC = (PROG_RAW < 1) ? 1 : PROG_RAW;
   localparam int TMR_W    = $clog2(PROG_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_SHORT = CNT_W'(START_BITS + OPC_W + ADDR_W);
   localparam logic [CNT_W-1:0] CNT_LONG  = CNT_W'(START_BITS + OPC_W + ADDR_W + DATA_W);
   localparam logic [TMR_W-1:0] TMR_LOAD  = TMR_W'(PROG_CYC);
   localparam logic [TMR_W-1:0] TMR_LAST  = TMR_W'(1);
   localparam logic [DATA_W-1:0] ERASED   = '1;

   spe_frame_if #(.SH_W(SH_W), .CNT_W(CNT_W)) frm ();

   spe_front #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_front (
      .sclk  (sclk),
      .cs    (cs),
      .din   (din),
      .rst_n (rst_n),
      .frm   (frm.front)
   );

   logic              cs_m_q;
   logic              cs_s_q;
   logic              cs_d_q;
   logic              st_m_q;
   logic              st_s_q;
   logic              st_d_q;
   logic              cs_fall;
   logic              start_evt;
   spe_state_t        st_q;
   logic [TMR_W-1:0]  timer_q;
   spe_cmd_t          cmd_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] data_q;
   logic              unlock_q;
   logic              ready_q;
   logic [DATA_W-1:0] mem_q [DEPTH];
   spe_cmd_t          cmd_dec;
   logic [ADDR_W-1:0] addr_dec;
   logic [DATA_W-1:0] data_dec;
   logic              is_prog;
   logic              launch;
   logic              finish;
   logic              busy;
   logic              used_q;
   logic              fresh;

   // Select and the start toggle both cross from the link side. The toggle
   // value taken at each select fall marks that frame as used up, so a status
   // poll without clocks cannot replay the frame that is still held there.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cs_m_q <= 1'b0;
         cs_s_q <= 1'b0;
         cs_d_q <= 1'b0;
         st_m_q <= 1'b0;
         st_s_q <= 1'b0;
         st_d_q <= 1'b0;
         used_q <= 1'b0;
      end
      else
      begin
         cs_m_q <= cs;
         cs_s_q <= cs_m_q;
         cs_d_q <= cs_s_q;
         st_m_q <= frm.start_tgl;
         st_s_q <= st_m_q;
         st_d_q <= st_s_q;
         if (cs_fall)
         begin
            used_q <= st_s_q;
         end
      end
   end

   assign cs_fall   = cs_d_q & ~cs_s_q;
   assign start_evt = st_s_q ^ st_d_q;
   assign busy      = (st_q == ST_BUSY);
   assign fresh     = st_s_q ^ used_q;

   function automatic spe_cmd_t decode_cmd(
      input logic [OPC_W-1:0] op,
      input logic [SUB_W-1:0] sub,
      input logic             long_frame
   );
      spe_cmd_t c;
      c = CMD_NONE;
      if (long_frame)
      begin
         if (op == OP_WRITE)
         begin
            c = CMD_WRITE;
         end
         else if (op == OP_MISC && sub == SUB_FILL_ALL)
         begin
            c = CMD_FILL_ALL;
         end
      end
      else
      begin
         if (op == OP_ERASE)
         begin
            c = CMD_ERASE;
         end
         else if (op == OP_MISC)
         begin
            case (sub)
               SUB_BULK_CLEAR: c = CMD_BULK_CLEAR;
               SUB_UNLOCK:     c = CMD_UNLOCK;
               SUB_LOCK:       c = CMD_LOCK;
               default:        c = CMD_NONE;
            endcase
         end
      end
      return c;
   endfunction

   // A frame whose pulse count matches neither length decodes to nothing,
   // which also covers select falling early or late after the data bits.
   always_comb
   begin
      cmd_dec  = CMD_NONE;
      addr_dec = '0;
      data_dec = '0;
      if (frm.count == CNT_LONG)
      begin
         addr_dec = frm.bits[DATA_W +: ADDR_W];
         data_dec = frm.bits[DATA_W-1:0];
         cmd_dec  = decode_cmd(frm.bits[SH_W-1 -: OPC_W],
                               addr_dec[ADDR_W-1 -: SUB_W], 1'b1);
      end
      else if (frm.count == CNT_SHORT)
      begin
         addr_dec = frm.bits[ADDR_W-1:0];
         cmd_dec  = decode_cmd(frm.bits[ADDR_W +: OPC_W],
                               addr_dec[ADDR_W-1 -: SUB_W], 1'b0);
      end
   end

   assign is_prog = (cmd_dec == CMD_WRITE) || (cmd_dec == CMD_ERASE) ||
                    (cmd_dec == CMD_BULK_CLEAR) || (cmd_dec == CMD_FILL_ALL);
   assign launch  = (st_q == ST_IDLE) && cs_fall && fresh && is_prog && unlock_q;
   assign finish  = busy && (timer_q == TMR_LAST);

   // The timer runs on the system clock only, so the serial clock may stop
   // or keep running once a cycle is under way.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         st_q    <= ST_IDLE;
         timer_q <= '0;
         cmd_q   <= CMD_NONE;
         addr_q  <= '0;
         data_q  <= '0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               if (launch)
               begin
                  st_q    <= ST_BUSY;
                  timer_q <= TMR_LOAD;
                  cmd_q   <= cmd_dec;
                  addr_q  <= addr_dec;
                  data_q  <= data_dec;
               end
            end
            ST_BUSY:
            begin
               timer_q <= timer_q - 1'b1;
               if (finish)
               begin
                  st_q <= ST_IDLE;
               end
            end
            default:
            begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Frames that end while busy are never looked at.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         unlock_q <= 1'b0;
      end
      else if (st_q == ST_IDLE && cs_fall && fresh && (cmd_dec == CMD_UNLOCK || cmd_dec == CMD_LOCK))
      begin
         unlock_q <= (cmd_dec == CMD_UNLOCK);
      end
   end

   // Reset stands for first power-up, so the array comes up erased.
   always_ff @(posedge clock)
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         if (!rst_n)
         begin
            mem_q[i] <= ERASED;
         end
         else if (launch && cmd_dec == CMD_WRITE && addr_dec == ADDR_W'(i))
         begin
            mem_q[i] <= ERASED;
         end
         else if (finish)
         begin
            case (cmd_q)
               CMD_ERASE:      mem_q[i] <= (addr_q == ADDR_W'(i)) ? ERASED : mem_q[i];
               CMD_WRITE:      mem_q[i] <= (addr_q == ADDR_W'(i)) ? data_q : mem_q[i];
               CMD_BULK_CLEAR: mem_q[i] <= ERASED;
               CMD_FILL_ALL:   mem_q[i] <= data_q;
               default:        mem_q[i] <= mem_q[i];
            endcase
         end
      end
   end

   // Completion wins over a coincident clear.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ready_q <= 1'b0;
      end
      else if (finish)
      begin
         ready_q <= 1'b1;
      end
      else if (cs_fall || start_evt)
      begin
         ready_q <= 1'b0;
      end
   end

   // Status shows only after select has passed the synchroniser, which is
   // the deselect_to_status_delay of this model.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         dout    <= 1'b0;
         dout_oe <= 1'b0;
      end
      else
      begin
         dout_oe <= cs_s_q && (busy || ready_q);
         dout    <= !busy && ready_q;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         peek_data <= '0;
      end
      else
      begin
         peek_data <= mem_q[peek_addr];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence frame_close_s;
      st_q == ST_IDLE && cs_fall && fresh;
   endsequence

   sequence good_prog_s;
      frame_close_s and (is_prog && unlock_q);
   endsequence

   busy_low_a: assert property ((busy && !finish && cs_s_q) |=> (dout_oe && !dout))
      else $error("busy status not driven low");
   ready_high_a: assert property ((ready_q && !busy && cs_s_q) |=> (dout_oe && dout))
      else $error("ready status not driven high");
   ready_drop_a: assert property ((ready_q && !finish && (cs_fall || start_evt)) |=> !ready_q)
      else $error("ready level not dropped");
   bad_count_a: assert property ((frame_close_s and (cmd_dec == CMD_NONE)) |=> st_q == ST_IDLE)
      else $error("bad pulse count started a cycle");
   locked_drop_a: assert property ((frame_close_s and !unlock_q) |=> (st_q == ST_IDLE) [*2])
      else $error("locked device started a cycle");
   launch_cycle_a: assert property (good_prog_s |=> (busy && timer_q == TMR_LOAD))
      else $error("program cycle not launched");
   timed_end_a: assert property (finish |=> (st_q == ST_IDLE && ready_q))
      else $error("cycle did not end on timer expiry");
   busy_ignore_a: assert property ((busy && !finish && cs_fall) |=> ($stable(cmd_q) && $stable(addr_q)))
      else $error("frame accepted while busy");
   erase_ones_a: assert property ((finish && cmd_q == CMD_ERASE) |=> mem_q[$past(addr_q)] == ERASED)
      else $error("erased location not all ones");
   pre_erase_a: assert property ((good_prog_s and (cmd_dec == CMD_WRITE)) |=> mem_q[addr_q] == ERASED)
      else $error("write did not pre-erase");
   fill_all_a: assert property ((finish && cmd_q == CMD_FILL_ALL) |=> mem_q[0] == $past(data_q))
      else $error("fill value not written");
   stale_frame_a: assert property ((st_q == ST_IDLE && cs_fall && !fresh) |=> st_q == ST_IDLE)
      else $error("used frame started a cycle again");

endmodule // spe_top

/* File: spe_master.sv */
`timescale 1ns/1ns
module spe_master
#(
   parameter int HALF_NS = 24
)
(
   // Serial link towards the device
   output logic sclk,
   output logic cs,
   output logic din
);
   initial
   begin
      sclk = 1'b0;
      cs   = 1'b0;
      din  = 1'b0;
   end

   // The link clock moves only here and inside frames; between them it stands still.
   task automatic pulse_clock(input int n);
      repeat (n)
      begin
         #HALF_NS sclk = 1'b1;
         #HALF_NS sclk = 1'b0;
      end
   endtask

   task automatic select(input logic v);
      cs = v;
   endtask

   // Bits go out MSB first, each set up while the clock is low.
   task automatic frame(input logic [31:0] bits, input int n);
      cs = 1'b1;
      for (int i = n - 1; i >= 0; i--)
      begin
         din = bits[i];
         #HALF_NS sclk = 1'b1;
         #HALF_NS sclk = 1'b0;
      end
      // Select drops before the next rising edge would come.
      cs  = 1'b0;
      // A released line must not keep looking like the last bit.
      din = ~din;
   endtask
endmodule // spe_master

/* File: tb_top.sv */
`timescale 1ns/1ns
module tb_top
   import spe_pkg::*;
;
   localparam int AW = DEF_ADDR_W;
   localparam int DW = DEF_DATA_W;
   localparam int PROG_NS = 2000;
   localparam int NA = 1 + OPC_W + AW;
   localparam int ND = NA + DW;
   localparam logic [AW-SUB_W-1:0] XA = '1;

   logic          clock = 1'b0;
   logic          rst_n = 1'b0;
   logic          sclk;
   logic          cs;
   logic          din;
   logic          dout;
   logic          dout_oe;
   logic [AW-1:0] peek_addr = '0;
   logic [DW-1:0] peek_data;
   int            fail_count = 0;
   int            compares = 0;
   logic [7:0]    v;

   always #(CLK_PERIOD_NS / 2) clock = ~clock;

   spe_master spe_master_i (.sclk(sclk), .cs(cs), .din(din));

   spe_top #(.ADDR_W(AW), .DATA_W(DW), .PROG_TIME_NS(PROG_NS)) spe_top_i (
      .clock(clock), .rst_n(rst_n), .sclk(sclk), .cs(cs), .din(din),
      .dout(dout), .dout_oe(dout_oe), .peek_addr(peek_addr), .peek_data(peek_data));

   task automatic give_verdict();
      $display("counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [7:0] d);
      peek_addr = a;
      step(2);
      d = 8'(peek_data);
   endtask

   // Select stays low at least four clocks so the frame is decoded first.
   task automatic send(input logic [31:0] bits, input int n);
      spe_master_i.frame(bits, n);
      step(6);
   endtask

   function automatic logic [31:0] fa(input logic [1:0] op, input logic [AW-1:0] a);
      return 32'({1'b1, op, a});
   endfunction

   function automatic logic [31:0] fd(input logic [1:0] op, input logic [AW-1:0] a, input logic [7:0] d);
      return 32'({1'b1, op, a, d});
   endfunction

   task automatic expect_busy();
      int n;
      spe_master_i.select(1'b1);
      step(3);
      chk(8'(dout_oe), 8'h01);
      chk(8'(dout), 8'h00);
      n = 0;
      while (dout !== 1'b1 && n < 120)
      begin
         step(1);
         n++;
      end
      chk(8'(dout), 8'h01);
      step(5);
      chk(8'({dout_oe, dout}), 8'h03);
      spe_master_i.select(1'b0);
      step(6);
      chk(8'(dout_oe), 8'h00);
   endtask

   task automatic expect_idle();
      spe_master_i.select(1'b1);
      step(4);
      chk(8'(dout_oe), 8'h00);
      spe_master_i.select(1'b0);
      step(5);
   endtask

   task automatic t_start();
      rd(9'h000, v);
      chk(v, 8'hff);
      rd(9'h1ff, v);
      chk(v, 8'hff);
      chk(8'(dout_oe), 8'h00);
      $display("test start done");
   endtask

   task automatic t_locked();
      send(fd(OP_WRITE, 9'h0a5, 8'h12), ND);
      expect_idle();
      rd(9'h0a5, v);
      chk(v, 8'hff);
      $display("test locked done");
   endtask

   task automatic t_write();
      send(fa(OP_MISC, {SUB_UNLOCK, XA}), NA);
      send(fd(OP_WRITE, 9'h0a5, 8'h0f), ND);
      expect_busy();
      send(fd(OP_WRITE, 9'h0a5, 8'hf0), ND);
      // A frame while busy keeps the link clock running and must be dropped.
      send(fd(OP_WRITE, 9'h15a, 8'h00), ND);
      expect_busy();
      rd(9'h0a5, v);
      chk(v, 8'hf0);
      rd(9'h15a, v);
      chk(v, 8'hff);
      $display("test write done");
   endtask

   task automatic t_count();
      send(fd(OP_WRITE, 9'h0a5, 8'h55) >> 1, ND - 1);
      expect_idle();
      send(fd(OP_WRITE, 9'h0a5, 8'h55) << 1, ND + 1);
      expect_idle();
      send(fa(OP_ERASE, 9'h0a5) << 1, NA + 1);
      expect_idle();
      rd(9'h0a5, v);
      chk(v, 8'hf0);
      $display("test count done");
   endtask

   task automatic t_erase();
      send(fa(OP_ERASE, 9'h0a5), NA);
      expect_busy();
      rd(9'h0a5, v);
      chk(v, 8'hff);
      $display("test erase done");
   endtask

   task automatic t_fill_clear();
      send(fd(OP_MISC, {SUB_FILL_ALL, XA}, 8'h3c), ND);
      expect_busy();
      rd(9'h000, v);
      chk(v, 8'h3c);
      rd(9'h1ff, v);
      chk(v, 8'h3c);
      send(fa(OP_MISC, {SUB_BULK_CLEAR, XA}), NA);
      expect_busy();
      rd(9'h000, v);
      chk(v, 8'hff);
      rd(9'h1ff, v);
      chk(v, 8'hff);
      $display("test fill and clear done");
   endtask

   task automatic t_lock();
      send(fa(OP_MISC, {SUB_LOCK, XA}), NA);
      send(fd(OP_WRITE, 9'h033, 8'h00), ND);
      expect_idle();
      rd(9'h033, v);
      chk(v, 8'hff);
      $display("test lock done");
   endtask

   initial
   begin
      // The link side clears only while its clock runs during reset.
      fork
         step(5);
         spe_master_i.pulse_clock(4);
      join
      rst_n = 1'b1;
      // The link side also leaves reset only on its own clock edges, so it
      // gets a few with select low before the first frame.
      spe_master_i.pulse_clock(3);
      step(2);
      t_start();
      t_locked();
      t_write();
      t_count();
      t_erase();
      t_fill_clear();
      t_lock();
      give_verdict();
   end

   initial
   begin
      #(20000 * CLK_PERIOD_NS);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      give_verdict();
   end
endmodule // tb_top
